// file: tb_two_wire_target_event_regs.sv
// self-checking bench for the event register bank
`timescale 1ns/1ps
module tb_two_wire_target_event_regs import two_wire_target_pkg::*;;
  logic clock = 0, rst = 1, wr_stb = 0, rd_stb = 0, rd_d = 0, suspend_task, arm_receive_task, irq;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, x = 32'd60981, v, exp_q[$];
  logic [5:0] fire = 6'h00, evt;
  logic [255:0] channel_out;
  int mismatches = 0, comparisons = 0, cycles = 0;
  logic [11:0] offs [15] = '{12'h14c, 12'h150, 12'h164, 12'h168, 12'h184, 12'h1a4, 12'h1cc,
    12'h1d0, 12'h1e4, 12'h1e8, 12'h200, 12'h300, 12'h304, 12'h7fc, 12'h030};
  two_wire_engine_model two_wire_engine_model_i (.clock, .rst, .fire, .evt);
  two_wire_target_event_regs two_wire_target_event_regs_i (.clock, .rst, .addr, .wdata,
    .wr_stb, .rd_stb, .rdata, .halt_done_evt(evt[0]), .fault_evt(evt[1]),
    .receive_started_evt(evt[2]), .transmit_started_evt(evt[3]), .write_command_evt(evt[4]),
    .read_command_evt(evt[5]), .channel_out, .suspend_task, .arm_receive_task, .irq);
  initial forever #25 clock = ~clock;
  function logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task chk(string n, logic [255:0] s, logic [255:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(logic [11:0] a, logic [31:0] d);
    @(posedge clock);
    {addr, wdata, wr_stb, rd_stb} <= {a, d, 2'b10};
  endtask : wr
  task rd(logic [11:0] a, logic [31:0] e);
    @(posedge clock);
    {addr, wr_stb, rd_stb} <= {a, 2'b01};
    exp_q.push_back(e);
  endtask : rd
  task idle();
    @(posedge clock);
    {wr_stb, rd_stb, fire} <= 8'h00;
  endtask : idle
  task close_out();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    rd_d <= rd_stb;
    cycles <= cycles + 1;
    if (rd_d)
      chk("rdata", rdata, exp_q.pop_front());
    if (cycles == 4000)
    begin
      mismatches++;
      close_out();
    end
  end
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    foreach (offs[i]) rd(offs[i], 32'h0);
    for (int i = 4; i < 12; i++)
    begin
      v = xs();
      wr(offs[i], v);
      rd(offs[i], v & (i == 10 ? short_mask : i == 11 ? ie_mask : cfg_mask));
    end
    wr(12'h300, 32'h0);
    wr(12'h304, 32'h1 << ie_tx_bit);
    wr(12'h304, 32'h0);
    rd(12'h304, 32'h1 << ie_tx_bit);
    idle();
    for (int e = 0; e < 2; e++)
      for (int i = 0; i < 6; i++)
      begin
        v = xs() & 32'hff;
        wr(12'h200, {30'h0, e[0], e[0]});
        wr(offs[i + 4], {e[0], 23'h0, v[7:0]});
        idle();
        @(posedge clock);
        fire <= 6'h01 << i;
        idle();
        @(posedge clock);
        #1;
        chk("channel", channel_out, e ? 256'h1 << v[7:0] : 256'h0);
        chk("suspend", suspend_task, e && i > 3);
        if (i > 1)
        begin
          rd(offs[i - 2], 32'h1);
          wr(offs[i - 2], 32'h0);
          rd(offs[i - 2], 32'h0);
          idle();
        end
      end
    wr(12'h300, 32'h1 << ie_write_bit);
    idle();
    @(posedge clock);
    fire <= 6'h10;
    idle();
    repeat (2) @(posedge clock);
    #1;
    chk("irq", irq, 1);
    wr(12'h300, 32'h0);
    idle();
    @(posedge clock);
    #1;
    chk("irq", irq, 0);
    wr(12'h300, 32'h1 << ie_write_bit);
    wr(12'h164, 32'h0);
    idle();
    @(posedge clock);
    #1;
    chk("irq", irq, 0);
    wr(12'h030, 32'h1);
    idle();
    #1;
    chk("arm", arm_receive_task, 1);
    repeat (3) idle();
    close_out();
  end
endmodule : tb_two_wire_target_event_regs

// file: two_wire_engine_model.sv
// protocol engine event source model
`timescale 1ns/1ps
module two_wire_engine_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [5:0] fire,
  output logic [5:0] evt
);
  always_ff @(posedge clock)
  begin
    evt <= rst ? 6'h00 : fire;
  end
endmodule : two_wire_engine_model

// file: two_wire_target_event_regs.sv
// event, broadcast, shortcut and interrupt enable registers of a two-wire target
//
// Contract
// - receive-started and transmit-started flags at bit 0, set when sequences begin.
// - write-command flag sets when addressed with a write command.
// - read-command flag sets when addressed with a read command.
// - broadcast registers hold channel index in low bits; halt-done one at 0x184.
// - top bit enables broadcast; zero means no channel driven, fault included.
// - receive-started event broadcast on its channel when enabled.
// - transmit-started event broadcast on its channel when enabled.
// - write- and read-command events broadcast on their channels when enabled.
// - shortcut bit 0 makes write-command trigger suspend.
// - shortcut bit 1 makes read-command trigger suspend.
// - interrupt enable bits 1, 9, 19, 20, 25, 26; one enables. Here bits 1 and 9 are stored but never raise irq.
// - arm-receive task prepares target for a write command.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module two_wire_target_event_regs
  import two_wire_target_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic halt_done_evt,
  input wire logic fault_evt,
  input wire logic receive_started_evt,
  input wire logic transmit_started_evt,
  input wire logic write_command_evt,
  input wire logic read_command_evt,
  output logic [255:0] channel_out,
  output logic suspend_task,
  output logic arm_receive_task,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic rx_flag_r;
  logic tx_flag_r;
  logic wr_flag_r;
  logic rd_flag_r;
  logic [31:0] cfg_r [num_cfg];
  logic [1:0] short_r;
  logic [31:0] ie_r;
  logic [31:0] rdata_nxt;
  logic [num_cfg-1:0] evt_vec;
  // address selects
  logic sel_rx_flag;
  logic sel_tx_flag;
  logic sel_wr_flag;
  logic sel_rd_flag;
  logic sel_event_task_shortcuts;
  logic sel_ie;
  logic sel_ie_set;
  logic sel_arm;
  logic [num_cfg-1:0] sel_cfg;
  // write enables
  logic we_rx_flag;
  logic we_tx_flag;
  logic we_wr_flag;
  logic we_rd_flag;
  logic we_event_task_shortcuts;
  logic we_ie;
  logic we_ie_set;
  logic we_arm;
  logic [num_cfg-1:0] we_cfg;
  // next values
  logic rx_flag_nxt;
  logic tx_flag_nxt;
  logic wr_flag_nxt;
  logic rd_flag_nxt;
  logic [1:0] short_nxt;
  logic [31:0] ie_nxt;
  logic suspend_nxt;
  logic arm_nxt;
  logic irq_nxt;
  logic [255:0] chan_nxt;
  // read groups and helpers
  logic [31:0] rd_flags;
  logic [31:0] rd_cfgs;
  logic [31:0] rd_ctrl;
  logic [31:0] pend_vec;
  logic [255:0] chan_part [num_cfg];
  logic [255:0] chan_acc [num_cfg+1];
  logic suspend_by_write;
  logic suspend_by_read;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign sel_rx_flag = addr == off_receive_started_flag;
  assign sel_tx_flag = addr == off_transmit_started_flag;
  assign sel_wr_flag = addr == off_write_command_flag;
  assign sel_rd_flag = addr == off_read_command_flag;
  assign sel_event_task_shortcuts = addr == off_event_task_shortcuts;
  assign sel_ie = addr == off_irq_enable;
  assign sel_ie_set = addr == off_irq_enable_set;
  assign sel_arm = addr == off_arm_receive_task;

  // write enables
  assign we_rx_flag = wr_stb && sel_rx_flag;
  assign we_tx_flag = wr_stb && sel_tx_flag;
  assign we_wr_flag = wr_stb && sel_wr_flag;
  assign we_rd_flag = wr_stb && sel_rd_flag;
  assign we_event_task_shortcuts = wr_stb && sel_event_task_shortcuts;
  assign we_ie = wr_stb && sel_ie;
  assign we_ie_set = wr_stb && sel_ie_set;
  assign we_arm = wr_stb && sel_arm;
  assign we_cfg = {num_cfg{wr_stb}} & sel_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // event flags
  function automatic logic flag_next(input logic cur, input logic evt, input logic wsel,
                                     input logic wbit);
    // event set wins over a software write in the same cycle
    if (evt)
      flag_next = 1'b1;
    else if (wsel)
      flag_next = wbit;
    else
      flag_next = cur;
  endfunction : flag_next

  // next values
  always_comb
  begin
    rx_flag_nxt = flag_next(rx_flag_r, receive_started_evt, we_rx_flag, wdata[0]);
    tx_flag_nxt = flag_next(tx_flag_r, transmit_started_evt, we_tx_flag, wdata[0]);
    wr_flag_nxt = flag_next(wr_flag_r, write_command_evt, we_wr_flag, wdata[0]);
    rd_flag_nxt = flag_next(rd_flag_r, read_command_evt, we_rd_flag, wdata[0]);
  end

  // receive-started flag
  always_ff @(posedge clock)
  begin
    if (rst)
      rx_flag_r <= 1'b0;
    else
      rx_flag_r <= rx_flag_nxt;
  end

  // transmit-started flag
  always_ff @(posedge clock)
  begin
    if (rst)
      tx_flag_r <= 1'b0;
    else
      tx_flag_r <= tx_flag_nxt;
  end

  // write-command flag
  always_ff @(posedge clock)
  begin
    if (rst)
      wr_flag_r <= 1'b0;
    else
      wr_flag_r <= wr_flag_nxt;
  end

  // read-command flag
  always_ff @(posedge clock)
  begin
    if (rst)
      rd_flag_r <= 1'b0;
    else
      rd_flag_r <= rd_flag_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // broadcast configuration and channel drive
  assign evt_vec = {read_command_evt, write_command_evt, transmit_started_evt,
                    receive_started_evt, fault_evt, halt_done_evt};

  function automatic logic [11:0] cfg_off(input int i);
    case (i)
      0: cfg_off = off_halt_done_broadcast_cfg;
      1: cfg_off = off_fault_broadcast_cfg;
      2: cfg_off = off_receive_started_broadcast_cfg;
      3: cfg_off = off_transmit_started_broadcast_cfg;
      4: cfg_off = off_write_command_broadcast_cfg;
      default: cfg_off = off_read_command_broadcast_cfg;
    endcase
  endfunction : cfg_off

  assign chan_acc[0] = '0;

  // per-slot storage and drive
  genvar g;
  generate
    for (g = 0; g < num_cfg; g++)
    begin : g_cfg
      logic pub_en;
      logic pub_fire;
      logic [chan_w-1:0] pub_idx;
      assign sel_cfg[g] = addr == cfg_off(g);
      assign pub_en = cfg_r[g][cfg_en_bit];
      assign pub_idx = cfg_r[g][chan_w-1:0];
      assign pub_fire = pub_en && evt_vec[g];
      // slot storage
      always_ff @(posedge clock)
      begin
        if (rst)
          cfg_r[g] <= reset_word;
        else if (we_cfg[g])
          cfg_r[g] <= wdata & cfg_mask;
      end
      // one-hot pulse on the selected channel only while enabled
      always_comb
      begin
        chan_part[g] = '0;
        if (pub_fire)
          chan_part[g][pub_idx] = 1'b1;
      end
      assign chan_acc[g + 1] = chan_acc[g] | chan_part[g];
    end
  endgenerate

  assign chan_nxt = chan_acc[num_cfg];

  // channel pulses, one cycle after the event
  always_ff @(posedge clock)
  begin
    if (rst)
      channel_out <= '0;
    else
      channel_out <= chan_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shortcuts
  always_comb
  begin
    short_nxt = short_r;
    if (we_event_task_shortcuts)
      short_nxt = wdata[1:0];
  end

  // shortcut register
  always_ff @(posedge clock)
  begin
    if (rst)
      short_r <= 2'b00;
    else
      short_r <= short_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks
  assign suspend_by_write = short_r[short_write_bit] && write_command_evt;
  assign suspend_by_read = short_r[short_read_bit] && read_command_evt;
  assign suspend_nxt = suspend_by_write || suspend_by_read;
  assign arm_nxt = we_arm && wdata[0];

  // suspend pulse
  always_ff @(posedge clock)
  begin
    if (rst)
      suspend_task <= 1'b0;
    else
      suspend_task <= suspend_nxt;
  end

  // arm-receive pulse, write-only trigger
  always_ff @(posedge clock)
  begin
    if (rst)
      arm_receive_task <= 1'b0;
    else
      arm_receive_task <= arm_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt enables
  always_comb
  begin
    ie_nxt = ie_r;
    if (we_ie)
      ie_nxt = wdata & ie_mask;
    else if (we_ie_set)
      ie_nxt = ie_r | (wdata & ie_mask);
  end

  // enable register
  always_ff @(posedge clock)
  begin
    if (rst)
      ie_r <= reset_word;
    else
      ie_r <= ie_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output
  // pending vector laid out on the enable positions
  always_comb
  begin
    pend_vec = reset_word;
    // halt-done and fault flags live outside this block
    pend_vec[ie_halt_bit] = 1'b0;
    pend_vec[ie_fault_bit] = 1'b0;
    pend_vec[ie_rx_bit] = rx_flag_r;
    pend_vec[ie_tx_bit] = tx_flag_r;
    pend_vec[ie_write_bit] = wr_flag_r;
    pend_vec[ie_read_bit] = rd_flag_r;
  end

  assign irq_nxt = |(pend_vec & ie_r);

  // level interrupt while any enabled flag stands
  always_ff @(posedge clock)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= irq_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  // flag group
  always_comb
  begin
    rd_flags = reset_word;
    case (addr)
      off_receive_started_flag: rd_flags[0] = rx_flag_r;
      off_transmit_started_flag: rd_flags[0] = tx_flag_r;
      off_write_command_flag: rd_flags[0] = wr_flag_r;
      off_read_command_flag: rd_flags[0] = rd_flag_r;
      default: rd_flags = reset_word;
    endcase
  end

  // broadcast configuration group
  always_comb
  begin
    rd_cfgs = reset_word;
    case (addr)
      off_halt_done_broadcast_cfg: rd_cfgs = cfg_r[0];
      off_fault_broadcast_cfg: rd_cfgs = cfg_r[1];
      off_receive_started_broadcast_cfg: rd_cfgs = cfg_r[2];
      off_transmit_started_broadcast_cfg: rd_cfgs = cfg_r[3];
      off_write_command_broadcast_cfg: rd_cfgs = cfg_r[4];
      off_read_command_broadcast_cfg: rd_cfgs = cfg_r[5];
      default: rd_cfgs = reset_word;
    endcase
  end

  // shortcut and enable group
  always_comb
  begin
    rd_ctrl = reset_word;
    case (addr)
      off_event_task_shortcuts: rd_ctrl[1:0] = short_r;
      off_irq_enable: rd_ctrl = ie_r;
      off_irq_enable_set: rd_ctrl = ie_r;
      default: rd_ctrl = reset_word;
    endcase
  end

  // unmapped offsets and the arm trigger read zero
  assign rdata_nxt = rd_flags | rd_cfgs | rd_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // read register
  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata <= reset_word;
    else if (rd_stb)
      rdata <= rdata_nxt;
    else
      rdata <= reset_word;
  end

endmodule : two_wire_target_event_regs

// file: two_wire_target_event_regs_properties.sv
// port assertions for the event register bank
`timescale 1ns/1ps
module event_regs_chk
  import two_wire_target_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  input wire logic halt_done_evt,
  input wire logic fault_evt,
  input wire logic receive_started_evt,
  input wire logic transmit_started_evt,
  input wire logic write_command_evt,
  input wire logic read_command_evt,
  input wire logic [255:0] channel_out,
  input wire logic suspend_task,
  input wire logic arm_receive_task,
  input wire logic irq
);
  wire logic [5:0] ev = {read_command_evt, write_command_evt, transmit_started_evt,
    receive_started_evt, fault_evt, halt_done_evt};
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("rdata not idle");
  a_chan_cause: assert property (!$past(|ev) |-> channel_out == 256'h0)
    else $error("channel without event");
  a_chan_count: assert property ($countones(channel_out) <= $countones($past(ev)))
    else $error("too many channels");
  a_suspend_cause: assert property (suspend_task |-> $past(ev[4]) || $past(ev[5]))
    else $error("suspend without command");
  a_arm_cause: assert property (arm_receive_task |->
    $past(wr_stb && addr == off_arm_receive_task && wdata[0])) else $error("arm uncaused");
  a_irq_rise: assert property ($rose(irq) |-> $past(wr_stb, 2) || $past(ev, 2) != 0)
    else $error("irq rise uncaused");
  a_irq_fall: assert property ($fell(irq) |-> $past(wr_stb, 2))
    else $error("irq fall uncaused");
  a_short_back: assert property (rd_stb && $past(wr_stb) &&
    addr == off_event_task_shortcuts && $past(addr) == addr |=>
    rdata == ($past(wdata, 2) & short_mask)) else $error("event_task_shortcuts");
endmodule : event_regs_chk
bind two_wire_target_event_regs event_regs_chk chk_i (.clock, .rst, .addr, .wdata, .wr_stb,
  .rd_stb, .rdata, .halt_done_evt, .fault_evt, .receive_started_evt, .transmit_started_evt,
  .write_command_evt, .read_command_evt, .channel_out, .suspend_task, .arm_receive_task, .irq);

// file: two_wire_target_pkg.sv
// shared constants for the two-wire target event register bank
package two_wire_target_pkg;
  localparam int addr_w = 12;
  localparam logic [11:0] off_arm_receive_task = 12'h030;
  localparam logic [11:0] off_receive_started_flag = 12'h14c;
  localparam logic [11:0] off_transmit_started_flag = 12'h150;
  localparam logic [11:0] off_write_command_flag = 12'h164;
  localparam logic [11:0] off_read_command_flag = 12'h168;
  localparam logic [11:0] off_halt_done_broadcast_cfg = 12'h184;
  localparam logic [11:0] off_fault_broadcast_cfg = 12'h1a4;
  localparam logic [11:0] off_receive_started_broadcast_cfg = 12'h1cc;
  localparam logic [11:0] off_transmit_started_broadcast_cfg = 12'h1d0;
  localparam logic [11:0] off_write_command_broadcast_cfg = 12'h1e4;
  localparam logic [11:0] off_read_command_broadcast_cfg = 12'h1e8;
  localparam logic [11:0] off_event_task_shortcuts = 12'h200;
  localparam logic [11:0] off_irq_enable = 12'h300;
  localparam logic [11:0] off_irq_enable_set = 12'h304;
  localparam int chan_w = 8;
  localparam int cfg_en_bit = 31;
  localparam int short_write_bit = 0;
  localparam int short_read_bit = 1;
  localparam int ie_halt_bit = 1;
  localparam int ie_fault_bit = 9;
  localparam int ie_rx_bit = 19;
  localparam int ie_tx_bit = 20;
  localparam int ie_write_bit = 25;
  localparam int ie_read_bit = 26;
  localparam logic [31:0] ie_mask = 32'h0618_0202;
  localparam logic [31:0] cfg_mask = 32'h8000_00ff;
  localparam logic [31:0] short_mask = 32'h0000_0003;
  localparam logic [31:0] reset_word = 32'h0000_0000;
  localparam int num_cfg = 6;
endpackage : two_wire_target_pkg
